/* File: hw/pph_dev_end.sv */
/*
 Card end of one parallel port: handshake, reply pulse timer, output
 latch fed by a write FIFO, input sampling and status word.
 Assumes the peer signals arrive asynchronously on the cable and the
 processor side is synchronous to clk.
*/
module pph_dev_end
    import pph_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // Cable
    pph_port_if.dev                port,
    // Processor side
    input  wire logic              dirOut,
    input  wire logic              cpuWrValid,
    input  wire logic [DATA_W-1:0] cpuWrData,
    output logic                   cpuWrReady,
    input  wire logic              cpuRdStrobe,
    output logic [DATA_W-1:0]      cpuRdData,
    output logic [DATA_W-1:0]      portControlStatus,
    // Interrupt option
    input  wire logic              replyInterruptJumper,
    output logic                   replyIrq
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchroniser

    logic [SYNC_W-1:0] s1_r;
    logic [SYNC_W-1:0] s2_r;
    logic [SYNC_W-1:0] s3_r;
    logic [SYNC_W-1:0] filt_r;
    logic [SYNC_W-1:0] filt_nxt;

    // Three-stage synchroniser
    // A bit moves only once stages two and three agree
    assign filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r | s3_r));

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_r   <= SYNC_RST;
            s2_r   <= SYNC_RST;
            s3_r   <= SYNC_RST;
            filt_r <= SYNC_RST;
        end
        else
        begin
            s1_r   <= {port.peerRequest_n, port.peerReply_n, port.busData};
            s2_r   <= s1_r;
            s3_r   <= s2_r;
            filt_r <= filt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded peer levels and edges

    logic              replyPrev_r;
    wire               reqOn     = (filt_r[SYNC_A] == LVL_ON);
    wire               replyOn   = (filt_r[SYNC_B] == LVL_ON);
    wire [DATA_W-1:0]  inWord    = filt_r[DATA_W-1:0];
    wire               replyRise = replyOn & ~replyPrev_r;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            replyPrev_r <= 1'b0;
        else
            replyPrev_r <= replyOn;
    end

    ////////////////////////////////////////////////////////////////////////
    // Write FIFO and output latch

    logic              fOutValid;
    logic [DATA_W-1:0] fOutData;
    logic              latchValid_r;
    logic [DATA_W-1:0] outLatch_r;
    pph_rply_t         state_r;
    pph_rply_t         state_nxt;
    logic [CNT_W-1:0]  cnt_r;
    logic [CNT_W-1:0]  cnt_nxt;

    wire               pulseIdle = (state_r == RP_IDLE);
    // Next written word goes out with a reply pulse
    wire               loadLatch = dirOut & fOutValid & pulseIdle & ~latchValid_r;
    // Peer reply frees the latch for the next word
    wire               ackLatch  = dirOut & latchValid_r & replyRise;
    // Buffer read in input mode fires a reply
    wire               readPulse = ~dirOut & cpuRdStrobe & pulseIdle;
    wire               startPulse = loadLatch | readPulse;

    pph_fifo #(
        .W     (DATA_W),
        .DEPTH (DEPTH)
    ) u_wrFifo (
        .clk      (clk),
        .arst_n   (arst_n),
        .inValid  (cpuWrValid),
        .inData   (cpuWrData),
        .inReady  (cpuWrReady),
        .outValid (fOutValid),
        .outData  (fOutData),
        .outReady (loadLatch)
    );

    // Output data held in a latch
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            latchValid_r <= 1'b0;
            outLatch_r   <= DATA_ZERO;
        end
        else
        begin
            if (loadLatch)
            begin
                latchValid_r <= 1'b1;
                outLatch_r   <= fOutData;
            end
            else if (ackLatch)
                latchValid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reply pulse timer

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            RP_IDLE:
            begin
                if (startPulse)
                begin
                    state_nxt = RP_PULSE;
                    cnt_nxt   = CNT_ZERO;
                end
            end
            RP_PULSE:
            begin
                if (cnt_r == REPLY_CNT_LAST)
                    state_nxt = RP_IDLE;
                else
                    cnt_nxt = cnt_r + CNT_ONE;
            end
            default:
            begin
                state_nxt = RP_IDLE;
                cnt_nxt   = CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= RP_IDLE;
            cnt_r   <= CNT_ZERO;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cable outputs

    assign port.portReadyOut_n   = dirOut ? LVL_OFF : LVL_ON;
    assign port.portReplyPulse_n = (state_r == RP_PULSE) ? LVL_ON : LVL_OFF;
    // Drivers on only with direction and request
    assign port.devDataOe        = dirOut & reqOn;
    assign port.devData          = outLatch_r;

    ////////////////////////////////////////////////////////////////////////
    // Processor read data, status and interrupt

    logic [DATA_W-1:0] rdData_r;
    logic [DATA_W-1:0] status_r;
    logic [DATA_W-1:0] status_nxt;
    logic              irq_r;

    always_comb
    begin
        status_nxt = DATA_ZERO;
        status_nxt[STAT_REQ_BIT]   = reqOn;
        status_nxt[STAT_LATCH_BIT] = latchValid_r;
        status_nxt[STAT_EMPTY_BIT] = ~fOutValid;
        status_nxt[STAT_DIR_BIT]   = dirOut;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdData_r <= DATA_ZERO;
            status_r <= DATA_ZERO;
            irq_r    <= 1'b0;
        end
        else
        begin
            // Unlatched input: the word is sampled at the read
            if (cpuRdStrobe)
                rdData_r <= inWord;
            status_r <= status_nxt;
            irq_r    <= replyInterruptJumper & replyRise;
        end
    end

    assign cpuRdData         = rdData_r;
    assign portControlStatus = status_r;
    assign replyIrq          = irq_r;
endmodule : pph_dev_end

/* File: pkg/pph_pkg.sv */
/*
 Constants, state codes and timing for the parallel port handshake pair.
 Assumes one 250 MHz clock for both ends and active-low handshake lines.
*/
// Function
// - Ready asserted while direction bit is clear
// - Input mode: reply pulse on buffer read
// - Output mode: reply pulse on buffer write; code pulses when a FIFO word loads the output latch
// - Drive data only with direction and request
// - Live request level shown in status bit 15
// - Jumper set: interrupt on each peer reply
// - Peer places word, then asserts reply
// - Peer asserts reply after taking output word
// - Input reply pulse 410 to 2000 ns
// - Output reply pulse 410 to 2000 ns
// - Peer reply held at least 270 ns
// - Peer releases drivers before asserting request
// - Peer holds input data until reply pulse
// - Peer reply kept until reply pulse begins
// - Handshake lines are active low
// - Data lines active high, output latched
package pph_pkg;
    localparam int DATA_W            = 16;
    localparam int FIFO_DEPTH        = 16;
    localparam int CLK_PERIOD_NS     = 4;
    localparam int REPLY_MIN_NS      = 410;
    localparam int REPLY_MAX_NS      = 2000;
    localparam int PEER_REPLY_MIN_NS = 270;
    localparam int REPLY_CYC      = (REPLY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REPLY_MAX_CYC  = REPLY_MAX_NS / CLK_PERIOD_NS;
    localparam int PEER_REPLY_CYC = (PEER_REPLY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W          = 10;
    localparam logic [CNT_W-1:0] REPLY_CNT_LAST = CNT_W'(REPLY_CYC - 1);
    localparam logic [CNT_W-1:0] PEER_CNT_LAST  = CNT_W'(PEER_REPLY_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO       = 10'h000;
    localparam logic [CNT_W-1:0] CNT_ONE        = 10'h001;
    // Active-low handshake levels
    localparam logic LVL_ON  = 1'b0;
    localparam logic LVL_OFF = 1'b1;
    // Status word fields
    localparam int STAT_REQ_BIT   = 15;
    localparam int STAT_LATCH_BIT = 2;
    localparam int STAT_EMPTY_BIT = 1;
    localparam int STAT_DIR_BIT   = 0;
    // Synchroniser: {strobe A, strobe B, data}
    localparam int SYNC_W = DATA_W + 2;
    localparam int SYNC_A = SYNC_W - 1;
    localparam int SYNC_B = SYNC_W - 2;
    localparam logic [SYNC_W-1:0] SYNC_RST = {2'h3, 16'h0000};
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

    typedef enum logic [1:0] {
        RP_IDLE  = 2'h1,
        RP_PULSE = 2'h2
    } pph_rply_t;

    typedef enum logic [3:0] {
        PS_IDLE  = 4'h1,
        PS_DRIVE = 4'h2,
        PS_SEND  = 4'h4,
        PS_ACK   = 4'h8
    } pph_peer_t;
endpackage : pph_pkg

/* File: pkg/pph_port_if.sv */
/*
 Port cable between the card end and the user device end.
 Assumes both ends share one clock; the bus level is resolved here.
*/
interface pph_port_if;
    import pph_pkg::*;
    logic              portReadyOut_n;
    logic              portReplyPulse_n;
    logic              peerRequest_n;
    logic              peerReply_n;
    logic [DATA_W-1:0] devData;
    logic              devDataOe;
    logic [DATA_W-1:0] peerData;
    logic              peerDataOe;
    logic [DATA_W-1:0] busData;

    // Undriven bus reads as zero; card driver wins a contention
    assign busData = devDataOe ? devData : (peerDataOe ? peerData : DATA_ZERO);

    modport dev (
        output portReadyOut_n, portReplyPulse_n, devData, devDataOe,
        input  peerRequest_n, peerReply_n, busData
    );
    modport peer (
        input  portReadyOut_n, portReplyPulse_n, busData,
        output peerRequest_n, peerReply_n, peerData, peerDataOe
    );
endinterface : pph_port_if

/* File: hw/pph_fifo.sv */
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes DEPTH is a power of two.
*/
module pph_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // Fill side
    input  wire logic         inValid,
    input  wire logic [W-1:0] inData,
    output logic              inReady,
    // Drain side
    output logic              outValid,
    output logic [W-1:0]      outData,
    input  wire logic         outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wrPtr_r;
    logic [AW:0]  rdPtr_r;

    wire          push  = inValid & inReady;
    wire          pop   = outValid & outReady;
    wire          empty = (wrPtr_r == rdPtr_r);
    wire          full  = (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]) & (wrPtr_r[AW] != rdPtr_r[AW]);

    assign inReady  = ~full;
    assign outValid = ~empty;
    assign outData  = mem[rdPtr_r[AW-1:0]];

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
        end
        else
        begin
            if (push)
                wrPtr_r <= wrPtr_r + 1'b1;
            if (pop)
                rdPtr_r <= rdPtr_r + 1'b1;
        end
    end

    // Storage needs no reset; empty flag guards stale words
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wrPtr_r[AW-1:0]] <= inData;
    end
endmodule : pph_fifo

/* File: hw/pph_peer_end.sv */
/*
 User device end of one parallel port: sends words in card input mode
 and receives words in card output mode.
 Assumes the card signals arrive asynchronously on the cable.
*/
module pph_peer_end
    import pph_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // Cable
    pph_port_if.peer               port,
    // Send side
    input  wire logic              txValid,
    input  wire logic [DATA_W-1:0] txData,
    output logic                   txReady,
    // Receive side
    input  wire logic              rxReady,
    output logic                   rxValid,
    output logic [DATA_W-1:0]      rxData
);
    logic [SYNC_W-1:0] s1_r;
    logic [SYNC_W-1:0] s2_r;
    logic [SYNC_W-1:0] s3_r;
    logic [SYNC_W-1:0] filt_r;
    logic              pulsePrev_r;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_r        <= SYNC_RST;
            s2_r        <= SYNC_RST;
            s3_r        <= SYNC_RST;
            filt_r      <= SYNC_RST;
            pulsePrev_r <= 1'b0;
        end
        else
        begin
            s1_r        <= {port.portReadyOut_n, port.portReplyPulse_n, port.busData};
            s2_r        <= s1_r;
            s3_r        <= s2_r;
            filt_r      <= (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
            pulsePrev_r <= (filt_r[SYNC_B] == LVL_ON);
        end
    end

    wire readyOn    = (filt_r[SYNC_A] == LVL_ON);
    wire pulseOn    = (filt_r[SYNC_B] == LVL_ON);
    wire pulseRise  = pulseOn & ~pulsePrev_r;
    // Word taken as the pulse ends: on a first word the card opens its
    // drivers only after our request crosses, well after the pulse starts
    wire pulseFall  = ~pulseOn & pulsePrev_r;

    ////////////////////////////////////////////////////////////////////////

    pph_peer_t         state_r;
    logic [CNT_W-1:0]  cnt_r;
    logic              seen_r;
    logic [DATA_W-1:0] drv_r;
    logic              rxValid_r;
    logic [DATA_W-1:0] rxData_r;

    wire cntDone = (cnt_r == PEER_CNT_LAST);
    // Request only with own drivers released
    wire reqOn   = ~readyOn & ~port.peerDataOe & (rxReady | (state_r == PS_ACK));
    wire take    = (state_r == PS_IDLE) & ~readyOn & reqOn & pulseFall;

    assign txReady = (state_r == PS_IDLE) & readyOn;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r   <= PS_IDLE;
            cnt_r     <= CNT_ZERO;
            seen_r    <= 1'b0;
            drv_r     <= DATA_ZERO;
            rxValid_r <= 1'b0;
            rxData_r  <= DATA_ZERO;
        end
        else
        begin
            rxValid_r <= take;
            case (state_r)
                PS_IDLE:
                begin
                    cnt_r  <= CNT_ZERO;
                    seen_r <= 1'b0;
                    if (txValid & txReady)
                    begin
                        drv_r   <= txData;
                        state_r <= PS_DRIVE;
                    end
                    else if (take)
                    begin
                        rxData_r <= filt_r[DATA_W-1:0];
                        state_r  <= PS_ACK;
                    end
                end
                // Data on the bus one cycle before reply
                PS_DRIVE:
                    state_r <= PS_SEND;
                PS_SEND:
                begin
                    if (!cntDone)
                        cnt_r <= cnt_r + CNT_ONE;
                    if (pulseRise)
                        seen_r <= 1'b1;
                    // Hold data and reply until pulse seen
                    if (cntDone & (seen_r | pulseOn))
                        state_r <= PS_IDLE;
                end
                // Reply held for the minimum width
                PS_ACK:
                begin
                    cnt_r <= cnt_r + CNT_ONE;
                    if (cntDone)
                        state_r <= PS_IDLE;
                end
                default:
                    state_r <= PS_IDLE;
            endcase
        end
    end

    assign port.peerRequest_n = reqOn ? LVL_ON : LVL_OFF;
    // Reply in receive only after the word is taken
    assign port.peerReply_n   = ((state_r == PS_SEND) | (state_r == PS_ACK)) ? LVL_ON : LVL_OFF;
    assign port.peerDataOe    = (state_r == PS_DRIVE) | (state_r == PS_SEND);
    assign port.peerData      = drv_r;
    assign rxValid            = rxValid_r;
    assign rxData             = rxData_r;
endmodule : pph_peer_end

/* File: bench/pph_chk.sv */
/*
 Cable checker for the card end and user device end of one port.
 Assumes one clock for both ends; takes the cable signals as plain inputs.
*/
module pph_chk
    import pph_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // Card side
    input  wire logic              portReadyOut_n,
    input  wire logic              portReplyPulse_n,
    input  wire logic [DATA_W-1:0] devData,
    input  wire logic              devDataOe,
    // Peer side
    input  wire logic              peerRequest_n,
    input  wire logic              peerReply_n,
    input  wire logic              peerDataOe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
////////////////////////////////////////////////////////////////
    logic [CNT_W-1:0] pulseLen_r;
    logic [CNT_W-1:0] pulseLen_nxt;
    logic [CNT_W-1:0] peerLen_r;
    logic [CNT_W-1:0] peerLen_nxt;
    // Saturate so a stuck line cannot wrap back into the legal window
    assign pulseLen_nxt = (portReplyPulse_n == LVL_OFF) ? CNT_ZERO
                        : (&pulseLen_r) ? pulseLen_r : pulseLen_r + CNT_ONE;
    assign peerLen_nxt  = (peerReply_n == LVL_OFF) ? CNT_ZERO
                        : (&peerLen_r) ? peerLen_r : peerLen_r + CNT_ONE;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pulseLen_r <= CNT_ZERO;
            peerLen_r  <= CNT_ZERO;
        end
        else
        begin
            pulseLen_r <= pulseLen_nxt;
            peerLen_r  <= peerLen_nxt;
        end
    end
////////////////////////////////////////////////////////////////
    // input pulse width
    a_in_pulse_width: assert property (
        $rose(portReplyPulse_n) && portReadyOut_n == LVL_ON |-> pulseLen_r >= REPLY_CYC)
        else $error("input reply pulse too short");
    a_out_pulse_width: assert property (
        $rose(portReplyPulse_n) && portReadyOut_n == LVL_OFF |-> pulseLen_r >= REPLY_CYC)
        else $error("output reply pulse too short");
    a_pulse_max_width: assert property (pulseLen_r <= REPLY_MAX_CYC)
        else $error("reply pulse too long");
    a_peer_reply_width: assert property (
        $rose(peerReply_n) |-> peerLen_r >= PEER_REPLY_CYC)
        else $error("peer reply too short");
    a_oe_needs_req: assert property (
        $rose(devDataOe) |-> peerRequest_n == LVL_ON && portReadyOut_n == LVL_OFF)
        else $error("card drives without request");
    a_oe_follows_req: assert property (
        $fell(peerRequest_n) && portReadyOut_n == LVL_OFF
        |-> ##[1:8] (devDataOe || peerRequest_n == LVL_OFF))
        else $error("card never drove after request");
    a_ready_no_drive: assert property (portReadyOut_n == LVL_ON |-> !devDataOe)
        else $error("card drives while ready");
    a_no_contention: assert property (!(devDataOe && peerDataOe))
        else $error("both ends drive the bus");
    a_setup_before_reply: assert property (
        $fell(peerReply_n) && portReadyOut_n == LVL_ON |-> peerDataOe && $past(peerDataOe))
        else $error("peer reply without data");
    a_hold_until_pulse: assert property (
        $fell(peerDataOe) |-> portReplyPulse_n == LVL_ON)
        else $error("peer data dropped early");
    a_reply_kept: assert property (
        $rose(peerReply_n) && portReadyOut_n == LVL_ON |-> portReplyPulse_n == LVL_ON)
        else $error("peer reply withdrawn early");
    a_out_data_steady: assert property (
        portReplyPulse_n == LVL_ON && $past(portReplyPulse_n) == LVL_ON |-> $stable(devData))
        else $error("latched data moved in pulse");
    c_input_xfer: cover property ($fell(peerReply_n) && portReadyOut_n == LVL_ON);
    c_output_pulse: cover property ($fell(portReplyPulse_n) && portReadyOut_n == LVL_OFF);
    c_card_drives: cover property ($rose(devDataOe));
endmodule : pph_chk

/* File: bench/parallel_port_handshake_tb.sv */
/*
 Testbench joining the card end and the user device end over one cable.
 Assumes the design's single 250 MHz clock and active-low async reset.
*/
module parallel_port_handshake_tb
    import pph_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic              clk = 1'b0;
    logic              arst_n;
    logic              dirOut;
    logic              cpuWrValid;
    logic [DATA_W-1:0] cpuWrData;
    logic              cpuWrReady;
    logic              cpuRdStrobe;
    logic [DATA_W-1:0] cpuRdData;
    logic [DATA_W-1:0] portControlStatus;
    logic              replyInterruptJumper;
    logic              replyIrq;
    logic              txValid;
    logic [DATA_W-1:0] txData;
    logic              txReady;
    logic              rxReady;
    logic              rxValid;
    logic [DATA_W-1:0] rxData;
    int                miscompares = 0;
    int                totalChecks = 0;
    int                cycles      = 0;
    int                irqSeen     = 0;
    always #2 clk = ~clk;
////////////////////////////////////////////////////////////////
    pph_port_if link ();
    pph_dev_end #(.DEPTH(FIFO_DEPTH)) pph_dev_end_i (
        .clk(clk), .arst_n(arst_n), .port(link.dev), .dirOut(dirOut),
        .cpuWrValid(cpuWrValid), .cpuWrData(cpuWrData), .cpuWrReady(cpuWrReady),
        .cpuRdStrobe(cpuRdStrobe), .cpuRdData(cpuRdData),
        .portControlStatus(portControlStatus),
        .replyInterruptJumper(replyInterruptJumper), .replyIrq(replyIrq));
    pph_peer_end pph_peer_end_i (
        .clk(clk), .arst_n(arst_n), .port(link.peer), .txValid(txValid),
        .txData(txData), .txReady(txReady), .rxReady(rxReady), .rxValid(rxValid),
        .rxData(rxData));
    pph_chk pph_chk_i (
        .clk(clk), .arst_n(arst_n), .portReadyOut_n(link.portReadyOut_n),
        .portReplyPulse_n(link.portReplyPulse_n), .devData(link.devData),
        .devDataOe(link.devDataOe), .peerRequest_n(link.peerRequest_n),
        .peerReply_n(link.peerReply_n), .peerDataOe(link.peerDataOe));
////////////////////////////////////////////////////////////////
    task automatic endOfTest();
        if (miscompares == 0 && totalChecks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : endOfTest

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Every wait after reset goes through here, so one global bound cuts any hang
    task automatic tick();
        @(posedge clk);
        #1;
        cycles++;
        if (replyIrq === 1'b1)
            irqSeen++;
        if (cycles > 40000)
        begin
            miscompares++;
            endOfTest();
        end
    endtask : tick

    task automatic pulseWidth(output int len);
        len = 0;
        while (link.portReplyPulse_n !== LVL_ON)
            tick();
        while (link.portReplyPulse_n === LVL_ON)
        begin
            len++;
            tick();
        end
    endtask : pulseWidth

    function automatic logic [15:0] word(input int i);
        return 16'h0f0f ^ 16'(i * 16'h1357);
    endfunction : word
////////////////////////////////////////////////////////////////
    task automatic inputXfer();
        int len;
        replyInterruptJumper = 1'b1;
        irqSeen = 0;
        check(16'(link.portReadyOut_n), 16'(LVL_ON));
        txData  = 16'hc3a5;
        txValid = 1'b1;
        while (txReady !== 1'b1)
            tick();
        tick();
        txValid = 1'b0;
        while (link.peerReply_n !== LVL_ON)
            tick();
        check(link.busData, 16'hc3a5);
        check(16'(link.devDataOe), 16'h0000);
        repeat (8) tick();
        check(16'(irqSeen), 16'h0001);
        cpuRdStrobe = 1'b1;
        tick();
        cpuRdStrobe = 1'b0;
        check(cpuRdData, 16'hc3a5);
        pulseWidth(len);
        check(16'(len), 16'(REPLY_CYC));
        check({15'h0000, portControlStatus[STAT_REQ_BIT]}, 16'h0000);
        check(16'(irqSeen), 16'h0001);
        check(portControlStatus, 16'h0002);
    endtask : inputXfer

    // Queue a full buffer in input mode, then drain it in output mode
    task automatic fillDrain();
        int len;
        replyInterruptJumper = 1'b0;
        irqSeen = 0;
        for (int i = 0; i < FIFO_DEPTH; i++)
        begin
            cpuWrValid = 1'b1;
            cpuWrData  = word(i);
            check(16'(cpuWrReady), 16'h0001);
            tick();
        end
        cpuWrValid = 1'b0;
        check(16'(cpuWrReady), 16'h0000);
        check(16'(link.portReplyPulse_n), 16'(LVL_OFF));
        rxReady = 1'b1;
        dirOut  = 1'b1;
        tick();
        check(16'(link.portReadyOut_n), 16'(LVL_OFF));
        pulseWidth(len);
        check(16'(len), 16'(REPLY_CYC));
        check(16'(link.devDataOe), 16'h0001);
        check({15'h0000, portControlStatus[STAT_REQ_BIT]}, 16'h0001);
        check(portControlStatus, 16'h8005);
        for (int i = 0; i < FIFO_DEPTH; i++)
        begin
            while (rxValid !== 1'b1)
                tick();
            check(rxData, word(i));
            tick();
        end
        repeat (8) tick();
        check(16'(irqSeen), 16'h0000);
        check(16'(cpuWrReady), 16'h0001);
        check(portControlStatus, 16'h8003);
    endtask : fillDrain
////////////////////////////////////////////////////////////////
    initial
    begin
        arst_n = 1'b0;
        dirOut = 1'b0;
        cpuWrValid = 1'b0;
        cpuWrData = DATA_ZERO;
        cpuRdStrobe = 1'b0;
        replyInterruptJumper = 1'b0;
        txValid = 1'b0;
        txData = DATA_ZERO;
        rxReady = 1'b0;
        repeat (12) @(posedge clk);
        #1;
        check(16'(link.portReplyPulse_n), 16'(LVL_OFF));
        check(16'(link.peerReply_n), 16'(LVL_OFF));
        arst_n = 1'b1;
        repeat (8) tick();
        inputXfer();
        fillDrain();
        endOfTest();
    end
endmodule : parallel_port_handshake_tb
